// ==== design/hioc_pkg.sv ====
package hioc_pkg;

  // ----------------------------------------
  // Host I/O addresses
  // ----------------------------------------
  localparam logic [15:0] CONFIG_ADDRESS_PORT_IO = 16'h0cf8;
  localparam logic [15:0] CONFIG_DATA_WINDOW_IO  = 16'h0cfc;

  // ----------------------------------------
  // Bridge configuration offsets
  // ----------------------------------------
  localparam logic [7:0] GATE_PORT_ADDRESS_OFS  = 8'h78;
  localparam logic [7:0] GATE_PORT_ADDRESS_OFS1 = 8'h79;
  localparam logic [7:0] POWER_MGMT_CONTROL_OFS = 8'h7a;
  localparam logic [7:0] GATE_PORT_OPTIONS_OFS  = 8'h7b;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0]  PCI_MASTER_GATE_RST     = 8'h00;
  localparam logic [15:0] GATE_PORT_ADDRESS_RST   = 16'h0022;
  localparam logic [7:0]  POWER_MGMT_CONTROL_RST  = 8'h00;
  localparam logic [7:0]  GATE_PORT_OPTIONS_RST   = 8'h00;
  localparam logic [31:0] CONFIG_ADDRESS_PORT_RST = 32'h00000000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BUS_GRANT_INHIBIT_BIT       = 0;
  localparam int GATE_PORT_DECODE_ENABLE_BIT = 6;
  localparam int GATE_PORT_SNOOP_FORWARD_BIT = 6;
  localparam int CONFIG_ACCESS_ENABLE_BIT    = 31;
  localparam logic [31:0] CONFIG_ADDRESS_WMASK = 32'h80fffffc;
  localparam logic [2:0]  OWN_UNIT           = 3'h0;
  localparam logic [4:0]  OWN_SLOT           = 5'h00;
  localparam logic [4:0]  MAX_IDSEL_SLOT     = 5'h14;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } hioc_io_req_type;

  typedef struct packed {
    logic        valid;
    logic        is_config;
    logic        config_type1;
    logic        idsel_none;
    logic        write;
    logic [31:0] addr;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
  } hioc_pci_req_type;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_BUSY
  } hioc_arb_state_type;

endpackage

// ==== design/hioc_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none
module hioc_arbiter #(
  parameter int MASTERS = 4
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               bus_grant_inhibit,
  input  wire logic               passive_release,
  input  wire logic               isa_bridge_hold_ack,
  input  wire logic               frame_active,
  input  wire logic [MASTERS-1:0] bus_req,
  output logic      [MASTERS-1:0] bus_gnt
);
  import hioc_pkg::*;

  hioc_arb_state_type          state;
  logic [MASTERS-1:0]          mask_req;
  logic [MASTERS-1:0]          next_gnt;
  logic                        isa_masked;

  // ----------------------------------------
  // Request masking
  // ----------------------------------------
  // ISA hold waits ack only under passive release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      isa_masked <= 1'b0;
    end else if (!bus_grant_inhibit) begin
      isa_masked <= 1'b0;
    end else if (!passive_release || isa_bridge_hold_ack) begin
      isa_masked <= 1'b1;
    end
  end

  always_comb begin
    mask_req = bus_req;
    if (bus_grant_inhibit) begin
      mask_req[MASTERS-1:1] = '0;
      if (isa_masked) begin
        mask_req[0] = 1'b0; // Master 0 is ISA bridge
      end
    end
    next_gnt = '0;
    for (int i = MASTERS - 1; i >= 0; i--) begin
      if (mask_req[i]) begin
        next_gnt = '0;
        next_gnt[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Grant state
  // ----------------------------------------
  // Running cycle completes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state   <= ARB_IDLE;
      bus_gnt <= '0;
    end else begin
      case (state)
        ARB_IDLE: begin
          bus_gnt <= next_gnt;
          if (|next_gnt) begin
            state <= ARB_BUSY;
          end
        end
        ARB_BUSY: begin
          if (!frame_active && !(|(bus_gnt & mask_req))) begin
            bus_gnt <= '0;
            state   <= ARB_IDLE;
          end
        end
        default: begin
          state   <= ARB_IDLE;
          bus_gnt <= '0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== design/hioc_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Eight-bit gate register, resets zero, only bit 0 used.
// - Gate port decoded at 16-bit address at 78h, reset 22h.
// - Inhibit bit set: arbiter grants no other PCI master.
// - Inhibit never aborts a PCI transaction already running.
// - Passive-release ISA hold masked only after its hold ack.
// - Decode enable 7Ah bit 6: zero forwards, one claims internally.
// - Snoop forward 7Bh bit 6: claimed accesses also go to PCI.
// - Config address at CF8h, dword only, resets zero, reserved bits.
// - Byte or word access at CF8h forwarded as PCI I/O.
// - Bit 31 enables configuration accesses.
// - Bus zero, not self: type 0 configuration cycle.
// - Bus nonzero: type 1, bus number on AD 23:16.
// - Data window CFCh reaches config space only when enabled.
// - Type 1 copies slot field onto AD 15:11.
// - Only unit zero answers; others give type 0 without select.
// - Reserved config reads return zero; writes ignored.
module hioc_decode #(
  parameter int MASTERS = 4
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire hioc_pkg::hioc_io_req_type io_req,
  output logic                           io_done,
  output logic [31:0]                    io_rdata,
  output hioc_pkg::hioc_pci_req_type     pci_req,
  input  wire logic                      passive_release,
  input  wire logic                      isa_bridge_hold_ack,
  input  wire logic                      frame_active,
  input  wire logic [MASTERS-1:0]        bus_req,
  output logic      [MASTERS-1:0]        bus_gnt
);
  import hioc_pkg::*;

  logic [7:0]  pci_master_gate;
  logic [15:0] gate_port_address;
  logic [7:0]  power_mgmt_control;
  logic [7:0]  gate_port_options;
  logic [31:0] config_address_port;
  logic        hold_ack_meta;
  logic        hold_ack_sync;
  logic        passive_meta;
  logic        passive_sync;
  logic        frame_meta;
  logic        frame_sync;
  logic [MASTERS-1:0] req_meta;
  logic [MASTERS-1:0] req_sync;

  logic        gate_port_decode_enable;
  logic        gate_port_snoop_forward;
  logic        config_access_enable;
  logic        hit_gate;
  logic        hit_caddr;
  logic        hit_cdata;
  logic        dword;
  logic        gate_claim;
  logic        caddr_claim;
  logic        cfg_self;
  logic        cfg_local;
  logic [7:0]  bus_num;
  logic [4:0]  target_slot_field;
  logic [2:0]  target_unit_field;
  logic [7:0]  cfg_ofs;
  logic [31:0] cfg_word;
  logic [31:0] cfg_wmask;
  logic [31:0] next_rdata;
  logic [31:0] idsel;

  assign gate_port_decode_enable =
    power_mgmt_control[GATE_PORT_DECODE_ENABLE_BIT];
  assign gate_port_snoop_forward =
    gate_port_options[GATE_PORT_SNOOP_FORWARD_BIT];
  assign config_access_enable =
    config_address_port[CONFIG_ACCESS_ENABLE_BIT];
  assign bus_num           = config_address_port[23:16];
  assign target_slot_field = config_address_port[15:11];
  assign target_unit_field = config_address_port[10:8];
  assign cfg_ofs           = {config_address_port[7:2], 2'b00};

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Two flops on every PCI-side input
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_ack_meta <= 1'b0;
      hold_ack_sync <= 1'b0;
      passive_meta  <= 1'b0;
      passive_sync  <= 1'b0;
      frame_meta    <= 1'b0;
      frame_sync    <= 1'b0;
      req_meta      <= '0;
      req_sync      <= '0;
    end else begin
      hold_ack_meta <= isa_bridge_hold_ack;
      hold_ack_sync <= hold_ack_meta;
      passive_meta  <= passive_release;
      passive_sync  <= passive_meta;
      frame_meta    <= frame_active;
      frame_sync    <= frame_meta;
      req_meta      <= bus_req;
      req_sync      <= req_meta;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Programmable gate address
  assign hit_gate  = io_req.valid && io_req.addr == gate_port_address
                     && io_req.byte_en[0];
  assign hit_caddr = io_req.valid && io_req.addr == CONFIG_ADDRESS_PORT_IO;
  assign hit_cdata = io_req.valid && io_req.addr == CONFIG_DATA_WINDOW_IO;
  assign dword     = io_req.byte_en == 4'hf;
  assign gate_claim  = hit_gate && gate_port_decode_enable;
  assign caddr_claim = hit_caddr && dword;
  assign cfg_self  = bus_num == 8'h00 && target_slot_field == OWN_SLOT
                     && target_unit_field == OWN_UNIT;
  assign cfg_local = hit_cdata && config_access_enable && cfg_self;

  // Bridge config word at current offset
  always_comb begin
    cfg_word  = '0;
    cfg_wmask = '0;
    case (cfg_ofs)
      GATE_PORT_ADDRESS_OFS: begin
        cfg_word  = {gate_port_options, power_mgmt_control,
                     gate_port_address};
        cfg_wmask = 32'hffffffff;
      end
      default: begin
        cfg_word  = '0;
        cfg_wmask = '0;
      end
    endcase
  end

  // Type 0 slot select, none above limit
  always_comb begin
    idsel = '0;
    if (target_slot_field <= MAX_IDSEL_SLOT
        && target_slot_field != OWN_SLOT && target_unit_field == OWN_UNIT) begin
      idsel[11 + target_slot_field] = 1'b1;
    end
  end

  // ----------------------------------------
  // Internal registers
  // ----------------------------------------
  // Gate register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pci_master_gate <= PCI_MASTER_GATE_RST;
    end else if (gate_claim && io_req.write) begin
      pci_master_gate <= {7'h00, io_req.wdata[BUS_GRANT_INHIBIT_BIT]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      config_address_port <= CONFIG_ADDRESS_PORT_RST;
    end else if (caddr_claim && io_req.write) begin
      config_address_port <= io_req.wdata & CONFIG_ADDRESS_WMASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_port_address  <= GATE_PORT_ADDRESS_RST;
      power_mgmt_control <= POWER_MGMT_CONTROL_RST;
      gate_port_options  <= GATE_PORT_OPTIONS_RST;
    end else if (cfg_local && io_req.write && |cfg_wmask) begin
      if (io_req.byte_en[0]) gate_port_address[7:0]  <= io_req.wdata[7:0];
      if (io_req.byte_en[1]) gate_port_address[15:8] <= io_req.wdata[15:8];
      if (io_req.byte_en[2]) power_mgmt_control      <= io_req.wdata[23:16];
      if (io_req.byte_en[3]) gate_port_options       <= io_req.wdata[31:24];
    end
  end

  // ----------------------------------------
  // Host answer
  // ----------------------------------------
  always_comb begin
    next_rdata = '0;
    if (gate_claim) begin
      next_rdata = {24'h000000, pci_master_gate};
    end else if (caddr_claim) begin
      next_rdata = config_address_port;
    end else if (cfg_local) begin
      next_rdata = cfg_word;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_done  <= 1'b0;
      io_rdata <= '0;
    end else begin
      io_done  <= io_req.valid;
      io_rdata <= io_req.write ? 32'h00000000 : next_rdata;
    end
  end

  // ----------------------------------------
  // PCI forwarding
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pci_req <= '0;
    end else begin
      pci_req <= '0;
      pci_req.write   <= io_req.write;
      pci_req.byte_en <= io_req.byte_en;
      pci_req.wdata   <= io_req.wdata;
      if (hit_cdata && config_access_enable && !cfg_self) begin
        pci_req.valid     <= 1'b1;
        pci_req.is_config <= 1'b1;
        if (bus_num != 8'h00) begin
          pci_req.config_type1 <= 1'b1;
          pci_req.addr <= {8'h00, bus_num, target_slot_field,
                           target_unit_field, cfg_ofs[7:2], 2'b01};
        end else begin
          pci_req.idsel_none <= ~|idsel;
          pci_req.addr <= {idsel[31:11], target_unit_field, cfg_ofs[7:2],
                           2'b00};
        end
      end else if (hit_gate) begin
        pci_req.valid <= !gate_port_decode_enable || gate_port_snoop_forward;
        pci_req.addr  <= {16'h0000, io_req.addr};
      end else if (hit_caddr && !dword) begin
        pci_req.valid <= 1'b1;
        pci_req.addr  <= {16'h0000, io_req.addr};
      end else if (io_req.valid && !hit_caddr && !hit_cdata) begin
        pci_req.valid <= 1'b1;
        pci_req.addr  <= {16'h0000, io_req.addr};
      end
    end
  end

  // ----------------------------------------
  // PCI arbiter
  // ----------------------------------------
  // Inhibit drives arbiter
  hioc_arbiter #(
    .MASTERS (MASTERS)
  ) u_arbiter (
    .ref_clk             (ref_clk),
    .rst                 (rst),
    .bus_grant_inhibit   (pci_master_gate[BUS_GRANT_INHIBIT_BIT]),
    .passive_release     (passive_sync),
    .isa_bridge_hold_ack (hold_ack_sync),
    .frame_active        (frame_sync),
    .bus_req             (req_sync),
    .bus_gnt             (bus_gnt)
  );

endmodule
`default_nettype wire

// ==== bench/hioc_decode_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module hioc_decode_props #(
  parameter int MASTERS = 4
) (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire hioc_pkg::hioc_io_req_type  io_req,
  input wire logic                       io_done,
  input wire logic [31:0]                io_rdata,
  input wire hioc_pkg::hioc_pci_req_type pci_req,
  input wire logic                       passive_release,
  input wire logic                       isa_bridge_hold_ack,
  input wire logic                       frame_active,
  input wire logic [MASTERS-1:0]         bus_req,
  input wire logic [MASTERS-1:0]         bus_gnt
);
  import hioc_pkg::*;

  logic cfg_en;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Shadow of the config enable bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_en <= 1'b0;
    end else if (io_req.valid && io_req.write && io_req.byte_en == 4'hf
                 && io_req.addr == CONFIG_ADDRESS_PORT_IO) begin
      cfg_en <= io_req.wdata[CONFIG_ACCESS_ENABLE_BIT];
    end
  end

  // ----------------------------------------
  // Request shapes
  // ----------------------------------------
  sequence cf8_full;
    io_req.valid && io_req.addr == CONFIG_ADDRESS_PORT_IO
      && io_req.byte_en == 4'hf;
  endsequence
  sequence cf8_part;
    io_req.valid && io_req.addr == CONFIG_ADDRESS_PORT_IO
      && io_req.byte_en != 4'hf;
  endsequence
  sequence cfc_off;
    io_req.valid && io_req.addr == CONFIG_DATA_WINDOW_IO && !cfg_en;
  endsequence
  sequence frame_held;
    frame_active[*3];
  endsequence

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Answer one cycle on
  done_timing_a: assert property (io_done == $past(io_req.valid))
    else $error("io_done not one cycle after request");
  cf8_claim_a: assert property (cf8_full |=> !pci_req.valid)
    else $error("dword address port access forwarded");
  cf8_pass_a: assert property (cf8_part |=> pci_req.valid
    && !pci_req.is_config && pci_req.addr[15:0] == CONFIG_ADDRESS_PORT_IO)
    else $error("partial address port access not forwarded");
  cfg_off_a: assert property (cfc_off |=> !pci_req.valid
    && io_rdata == 32'h0)
    else $error("data window used while disabled");
  type1_bus_a: assert property (pci_req.valid && pci_req.config_type1
    |-> pci_req.addr[23:16] != 8'h00 && pci_req.addr[1:0] == 2'b01)
    else $error("type 1 cycle with bad address phase");
  type0_sel_a: assert property (pci_req.valid && pci_req.is_config
    && !pci_req.config_type1 && !pci_req.idsel_none
    |-> $onehot(pci_req.addr[31:11]) && !pci_req.addr[11])
    else $error("type 0 cycle with bad select line");
  grant_hold_a: assert property (frame_held ##0 bus_gnt != '0
    |=> $stable(bus_gnt))
    else $error("grant changed during a transaction");
  grant_cause_a: assert property (((bus_gnt & ~$past(bus_gnt))
    & ~$past(bus_req, 3)) == '0)
    else $error("grant without an earlier request");
  grant_onehot_a: assert property ($onehot0(bus_gnt))
    else $error("more than one grant");
endmodule

bind hioc_decode hioc_decode_props #(.MASTERS(MASTERS)) hioc_decode_props_inst (
  .ref_clk(ref_clk), .rst(rst), .io_req(io_req), .io_done(io_done),
  .io_rdata(io_rdata), .pci_req(pci_req),
  .passive_release(passive_release),
  .isa_bridge_hold_ack(isa_bridge_hold_ack),
  .frame_active(frame_active), .bus_req(bus_req), .bus_gnt(bus_gnt)
);
`default_nettype wire

// ==== bench/hioc_pci_agent.sv ====
`timescale 1ns/1ps
`default_nettype none
module hioc_pci_agent (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] want,
  input  wire logic       hold_cmd,
  input  wire logic [3:0] bus_gnt,
  output logic      [3:0] bus_req,
  output logic            frame_active,
  output logic            isa_bridge_hold_ack
);
  // Masters request while they want the bus
  assign bus_req = want;

  // Granted master runs a transaction while it still wants
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_active <= 1'b0;
    end else begin
      frame_active <= |(bus_gnt & want);
    end
  end

  // Bridge signals hold ack on command
  assign isa_bridge_hold_ack = hold_cmd;
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hioc_pkg::*;

  localparam logic [15:0] AP = CONFIG_ADDRESS_PORT_IO;
  localparam logic [15:0] DW = CONFIG_DATA_WINDOW_IO;

  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  hioc_io_req_type  io_req = '0;
  logic             io_done;
  logic [31:0]      io_rdata;
  hioc_pci_req_type pci_req;
  hioc_pci_req_type pr;
  logic             passive_release = 1'b0;
  logic             hold_cmd = 1'b0;
  logic [3:0]       want = 4'h0;
  logic             frame_active;
  logic             isa_bridge_hold_ack;
  logic [3:0]       bus_req;
  logic [3:0]       bus_gnt;
  logic [31:0]      rd;
  int               hits;
  int               fail_count = 0;
  int               check_count = 0;

  // Clock
  always #5 ref_clk = ~ref_clk;

  hioc_decode #(.MASTERS(4)) hioc_decode_inst (
    .ref_clk(ref_clk), .rst(rst), .io_req(io_req), .io_done(io_done),
    .io_rdata(io_rdata), .pci_req(pci_req),
    .passive_release(passive_release),
    .isa_bridge_hold_ack(isa_bridge_hold_ack),
    .frame_active(frame_active), .bus_req(bus_req), .bus_gnt(bus_gnt));
  hioc_pci_agent hioc_pci_agent_inst (
    .ref_clk(ref_clk), .rst(rst), .want(want), .hold_cmd(hold_cmd),
    .bus_gnt(bus_gnt), .bus_req(bus_req), .frame_active(frame_active),
    .isa_bridge_hold_ack(isa_bridge_hold_ack));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One request, answer captured a cycle later
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [3:0] be, input logic [31:0] d);
    io_req = '{valid: 1'b1, write: w, addr: a, byte_en: be, wdata: d};
    @(negedge ref_clk);
    rd = io_rdata;
    pr = pci_req;
    chk_bit(io_done, 1'b1, "done");
  endtask

  task automatic idle;
    io_req.valid = 1'b0;
    @(negedge ref_clk);
  endtask

  // Access with expected data and forwarding
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [3:0] be, input logic [31:0] d, e,
                     input logic f);
    io(w, a, be, d);
    chk_val(rd, e, "rdata");
    chk_bit(pr.valid, f, "forward");
    idle();
  endtask

  task automatic gnt_watch(input logic [3:0] m, input int n);
    hits = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if ((bus_gnt & m) != 4'h0) hits++;
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    acc(0, AP, 4'hf, 0, 32'h0, 0);
    acc(1, AP, 4'hf, 32'h8000_0078, 0, 0);
    acc(0, DW, 4'hf, 0, 32'h0000_0022, 0);
    acc(0, 16'h22, 4'h1, 0, 0, 1);
    acc(1, DW, 4'h4, 32'h0040_0000, 0, 0);
    acc(0, 16'h22, 4'h1, 0, 32'h0, 0);
    acc(1, 16'h22, 4'h1, 32'h1, 0, 0);
    acc(0, 16'h22, 4'h1, 0, 32'h1, 0);
    want = 4'h2;
    gnt_watch(4'h2, 12);
    chk_val(hits, 0, "grant inhibited");
    acc(1, 16'h22, 4'h1, 32'h0, 0, 0);
    gnt_watch(4'h2, 8);
    chk_bit(hits != 0, 1'b1, "grant resumed");
    acc(1, 16'h22, 4'h1, 32'h1, 0, 0);
    gnt_watch(4'h2, 8);
    chk_val(hits, 8, "grant kept");
    want = 4'h0;
    gnt_watch(4'hf, 6);
    acc(1, DW, 4'h8, 32'h4000_0000, 0, 0);
    acc(1, 16'h22, 4'h1, 32'h0, 0, 1);
    acc(0, 16'h22, 4'h1, 0, 32'h0, 1);
    acc(1, DW, 4'h4, 32'h0, 0, 0);
    acc(1, 16'h22, 4'h1, 32'h1, 0, 1);
    acc(1, DW, 4'h4, 32'h0040_0000, 0, 0);
    acc(0, 16'h22, 4'h1, 0, 32'h0, 1);
    // Passive release settles before inhibit is set
    passive_release = 1'b1;
    acc(1, DW, 4'h3, 32'h0000_0030, 0, 0);
    acc(1, DW, 4'h8, 32'h0, 0, 0);
    acc(1, 16'h30, 4'h1, 32'h1, 0, 0);
    acc(0, 16'h30, 4'h1, 0, 32'h1, 0);
    acc(0, 16'h22, 4'h1, 0, 32'h0, 1);
    want = 4'h1;
    gnt_watch(4'h1, 10);
    chk_bit(hits != 0, 1'b1, "bridge before ack");
    want = 4'h0;
    hold_cmd = 1'b1;
    gnt_watch(4'hf, 6);
    want = 4'h1;
    gnt_watch(4'h1, 12);
    chk_val(hits, 0, "bridge after ack");
    want = 4'h0;
    hold_cmd = 1'b0;
    passive_release = 1'b0;
    acc(1, AP, 4'h1, 32'hff, 0, 1);
    chk_val(pr.wdata, 32'hff, "forward data");
    chk_val({27'h0, pr.write, pr.byte_en}, 32'h11, "forward lanes");
    acc(0, AP, 4'hf, 0, 32'h8000_0078, 0);
    acc(1, AP, 4'hf, 32'hff00_0003, 0, 0);
    acc(0, AP, 4'hf, 0, 32'h8000_0000, 0);
    io(1, AP, 4'hf, 32'h8005_1a04);
    io(0, DW, 4'hf, 0);
    chk_bit(pr.valid & pr.config_type1, 1'b1, "type 1");
    chk_val(pr.addr, 32'h0005_1a05, "type 1 address");
    idle();
    acc(1, AP, 4'hf, 32'h8000_1800, 0, 0);
    io(0, DW, 4'hf, 0);
    chk_bit(pr.valid & ~pr.config_type1, 1'b1, "type 0");
    chk_val({11'h0, pr.addr[31:11]}, 32'h8, "select line");
    idle();
    acc(1, AP, 4'hf, 32'h8000_0100, 0, 0);
    io(0, DW, 4'hf, 0);
    chk_bit(pr.valid & pr.idsel_none, 1'b1, "no select");
    idle();
    acc(1, AP, 4'hf, 32'h0000_0078, 0, 0);
    acc(0, DW, 4'hf, 0, 32'h0, 0);
    acc(1, DW, 4'hf, 32'hffff_ffff, 0, 0);
    acc(1, AP, 4'hf, 32'h8000_0078, 0, 0);
    acc(0, DW, 4'hf, 0, 32'h0040_0030, 0);
    acc(1, AP, 4'hf, 32'h8000_0040, 0, 0);
    acc(1, DW, 4'hf, 32'h1234_5678, 0, 0);
    acc(0, DW, 4'hf, 0, 32'h0, 0);
    acc(1, AP, 4'hf, 32'h8000_0078, 0, 0);
    acc(0, DW, 4'hf, 0, 32'h0040_0030, 0);
    close_out();
  end
endmodule
`default_nettype wire
